// ### rtl/ats_pkg.sv
// Package with constants and carrier types of the trigger sequencer
package ats_pkg;
	localparam int ATS_CHANNELS = 16;
	localparam logic [3:0] ATS_TRIG_SRC_RST = 4'hf;
	localparam int ATS_SEQ_LEN = 8;
	localparam logic [3:0] ATS_SEQ_CNT_MAX = 4'h7;
	localparam logic [11:0] ATS_RESULT_RST = 12'h000;
	localparam logic [15:0] ATS_DIEN_RST = 16'h0000;

	// Mode settings from software
	typedef struct packed {
		logic trig_enable;
		logic trig_level_select;
		logic trig_polarity;
		logic scan_mode;
		logic [3:0] trig_source;
	} ats_cfg_type;

	// Interrupt local enables and global mask
	typedef struct packed {
		logic seq_complete_irq_en;
		logic compare_irq_en;
		logic global_irq_mask;
	} ats_irq_cfg_type;

	// Result of one conversion from the analog sub-block
	typedef struct packed {
		logic [3:0] channel;
		logic [11:0] value;
		logic compare_hit;
	} ats_conv_type;
endpackage : ats_pkg

// ### rtl/ats_sync.sv
// Two-stage synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module ats_sync
	import ats_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Level in and out
	input wire logic d,
	output logic q
);
	logic meta_q;

	// First stage read only by second stage
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_q <= 1'b0;
			q <= 1'b0;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : ats_sync
`default_nettype wire

// ### rtl/ats_sequencer.sv
// Conversion sequencer with external trigger, interrupts and pad enables
// Summary of operation
// - Trigger off, scan off: one sequence per start then stop.
// - Trigger off, scan on: back-to-back sequences, trigger ignored.
// - Edge mode: one sequence per edge; polarity 0 falling, 1 rising.
// - Level mode: convert while trigger active; polarity 0 low, 1 high.
// - In edge mode an active edge during a conversion sets the overrun flag.
// - In trigger modes the first conversion waits for the trigger.
// - With trigger enabled a software start is ignored.
// - Level mode release and reassert mid-sequence is no overrun.
// - Level still active at sequence end starts another at once.
// - Trigger source resets to channel 15, selectable by field.
// - Pads always feed analog; digital buffer per-channel enable.
// - Reset enters power-down with all bits but the compare values at reset values.
// - Complete and compare requests gated by own enable and mask.
// - Auto compare channel keeps compare value, result discarded.
`timescale 1ns/1ps
`default_nettype none
module ats_sequencer
	import ats_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Configuration
	input wire ats_cfg_type cfg,
	input wire ats_irq_cfg_type irq_cfg,
	input wire logic [15:0] digital_input_enable,
	input wire logic [15:0] auto_compare_en,
	// Software start (write of sequence_start_ctrl) and flag clear
	input wire logic sw_start,
	input wire logic overrun_clear,
	input wire logic seq_done_clear,
	input wire logic compare_clear,
	// Pads and analog sub-block
	input wire logic [15:0] pad_in,
	input wire logic conv_done,
	input wire ats_conv_type conv_result,
	// Compare value write per channel
	input wire logic cmp_wr,
	input wire logic [3:0] cmp_wr_channel,
	input wire logic [11:0] cmp_wr_value,
	// Outputs
	output logic conv_start,
	output logic [3:0] conv_channel,
	output logic analog_power_on,
	output logic busy,
	output logic trig_overrun_flag,
	output logic seq_done_flag,
	output logic compare_flag,
	output logic seq_complete_irq,
	output logic compare_irq,
	output logic [15:0] digital_port_in,
	output logic [11:0] result_value,
	output logic [3:0] result_channel,
	output logic result_valid
);
	typedef enum logic [1:0] {ATS_IDLE, ATS_START, ATS_WAIT} ats_state_type;
	ats_state_type state_q;
	logic trig_raw;
	logic trig_s;
	logic trig_prev_q;
	logic trig_active;
	logic edge_hit;
	logic [3:0] cnt_q;
	logic seq_last;
	logic launch;
	logic again;
	logic [3:0] src_q;
	logic [11:0] cmp_mem [ATS_CHANNELS];

	// Trigger source register, channel 15 out of reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			src_q <= ATS_TRIG_SRC_RST;
		else
			src_q <= cfg.trig_source;
	end

	// Selected pad as trigger source
	assign trig_raw = pad_in[src_q];

	ats_sync u_trig_sync (
		.clk(clk),
		.rst(rst),
		.d(trig_raw),
		.q(trig_s)
	);

	// Previous synchronised level for edge detection
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			trig_prev_q <= 1'b0;
		else
			trig_prev_q <= trig_s;
	end

	// Polarity picks active level and edge
	assign trig_active = cfg.trig_polarity ? trig_s : ~trig_s;
	assign edge_hit = cfg.trig_polarity ? (trig_s & ~trig_prev_q)
		: (~trig_s & trig_prev_q);
	assign seq_last = (cnt_q == ATS_SEQ_CNT_MAX) && conv_done;

	// Software start only counts with trigger disabled
	// Trigger modes launch only on the trigger condition
	always_comb
	begin
		launch = 1'b0;
		if (!cfg.trig_enable)
			launch = sw_start;
		else if (cfg.trig_level_select)
			launch = trig_active;
		else
			launch = edge_hit;
	end

	// Scan restarts; active level restarts; else stop
	always_comb
	begin
		again = 1'b0;
		if (!cfg.trig_enable)
			again = cfg.scan_mode;
		else if (cfg.trig_level_select)
			again = trig_active;
	end

	// Sequence state; reset leaves converter powered down
	// Power-down idle after reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= ATS_IDLE;
			cnt_q <= 4'h0;
		end
		else
		begin
			case (state_q)
				ATS_IDLE:
				begin
					cnt_q <= 4'h0;
					if (launch)
						state_q <= ATS_START;
				end
				ATS_START:
					state_q <= ATS_WAIT;
				ATS_WAIT:
				begin
					if (conv_done)
					begin
						if (!seq_last)
						begin
							cnt_q <= cnt_q + 4'h1;
							state_q <= ATS_START;
						end
						else if (again)
						begin
							cnt_q <= 4'h0;
							state_q <= ATS_START;
						end
						else
							state_q <= ATS_IDLE;
					end
				end
				default:
					state_q <= ATS_IDLE;
			endcase
		end
	end

	// Start pulse and channel towards the analog sub-block
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			conv_start <= 1'b0;
			conv_channel <= 4'h0;
			busy <= 1'b0;
			analog_power_on <= 1'b0;
		end
		else
		begin
			conv_start <= (state_q == ATS_START);
			conv_channel <= cnt_q;
			busy <= (state_q != ATS_IDLE);
			// Powered only while converting, saving analog current
			analog_power_on <= (state_q != ATS_IDLE);
		end
	end

	// Edge during a sequence sets overrun, set beats clear
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			trig_overrun_flag <= 1'b0;
		else if (cfg.trig_enable && !cfg.trig_level_select && edge_hit
			&& state_q != ATS_IDLE)
			trig_overrun_flag <= 1'b1;
		else if (overrun_clear)
			trig_overrun_flag <= 1'b0;
	end

	// Compare values held per channel
	always_ff @(posedge clk)
	begin
		if (cmp_wr)
			cmp_mem[cmp_wr_channel] <= cmp_wr_value;
	end

	// Compare channels discard result; others publish it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			result_valid <= 1'b0;
			result_value <= ATS_RESULT_RST;
			result_channel <= 4'h0;
		end
		else
		begin
			result_valid <= conv_done && state_q == ATS_WAIT
				&& !auto_compare_en[conv_result.channel];
			if (conv_done && !auto_compare_en[conv_result.channel])
			begin
				result_value <= conv_result.value;
				result_channel <= conv_result.channel;
			end
		end
	end

	// Sticky event flags, set beats clear
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			seq_done_flag <= 1'b0;
			compare_flag <= 1'b0;
		end
		else
		begin
			if (seq_last && state_q == ATS_WAIT)
				seq_done_flag <= 1'b1;
			else if (seq_done_clear)
				seq_done_flag <= 1'b0;
			if (conv_done && state_q == ATS_WAIT
				&& auto_compare_en[conv_result.channel]
				&& conv_result.value
				== cmp_mem[conv_result.channel])
				compare_flag <= 1'b1;
			else if (compare_clear)
				compare_flag <= 1'b0;
		end
	end

	// Requests gated by local enables and global mask
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			seq_complete_irq <= 1'b0;
			compare_irq <= 1'b0;
		end
		else
		begin
			seq_complete_irq <= seq_done_flag
				& irq_cfg.seq_complete_irq_en & ~irq_cfg.global_irq_mask;
			compare_irq <= compare_flag & irq_cfg.compare_irq_en
				& ~irq_cfg.global_irq_mask;
		end
	end

	// Digital buffer per pad; analog path untouched
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			digital_port_in <= ATS_DIEN_RST;
		else
			digital_port_in <= pad_in & digital_input_enable;
	end

	// Trigger source is channel 15 out of reset
	chk_src_reset: assert property (@(posedge clk) $fell(rst) |->
		src_q == ATS_TRIG_SRC_RST)
		else $error("trigger source check");

	// Overrun set after edge while busy
	chk_overrun_set: assert property (@(posedge clk) disable iff (rst)
		cfg.trig_enable && !cfg.trig_level_select && edge_hit
		&& state_q != ATS_IDLE |=> trig_overrun_flag)
		else $error("overrun not set");

	chk_level_nover: assert property (@(posedge clk) disable iff (rst)
		cfg.trig_enable && cfg.trig_level_select && !overrun_clear
		|=> trig_overrun_flag == $past(trig_overrun_flag))
		else $error("overrun changed in level mode");

	// Software start ignored with edge trigger enabled
	chk_sw_ignored: assert property (@(posedge clk) disable iff (rst)
		state_q == ATS_IDLE && cfg.trig_enable && !cfg.trig_level_select
		&& !edge_hit |=> state_q == ATS_IDLE)
		else $error("start without trigger");

	chk_single_stop: assert property (@(posedge clk) disable iff (rst)
		state_q == ATS_WAIT && seq_last && !cfg.trig_enable
		&& !cfg.scan_mode |=> state_q == ATS_IDLE)
		else $error("single sequence did not stop");

	chk_level_again: assert property (@(posedge clk) disable iff (rst)
		state_q == ATS_WAIT && seq_last && cfg.trig_enable
		&& cfg.trig_level_select && trig_active |=> state_q == ATS_START)
		else $error("no restart in level mode");

	chk_scan_run: assert property (@(posedge clk) disable iff (rst)
		state_q == ATS_WAIT && seq_last && !cfg.trig_enable
		&& cfg.scan_mode |=> state_q == ATS_START ##1 conv_start)
		else $error("scan stopped");

	chk_irq_mask: assert property (@(posedge clk) disable iff (rst)
		irq_cfg.global_irq_mask |=> !seq_complete_irq && !compare_irq)
		else $error("masked irq raised");

	chk_cmp_discard: assert property (@(posedge clk) disable iff (rst)
		conv_done && auto_compare_en[conv_result.channel]
		|=> !result_valid)
		else $error("compare result stored");
endmodule : ats_sequencer
`default_nettype wire

// ### verification/ats_partner.sv
// Analog sub-block model answering each conversion start
`timescale 1ns/1ps
`default_nettype none
module ats_partner
	import ats_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Requests from the sequencer
	input wire logic conv_start,
	input wire logic [3:0] conv_channel,
	// Answer
	output logic conv_done,
	output ats_conv_type conv_result
);
	logic run_q;
	logic [1:0] wait_q;
	logic [3:0] chan_q;
	// Done four cycles after start; result scrambled outside the pulse
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			run_q <= 1'b0;
			wait_q <= 2'h0;
			chan_q <= 4'h0;
			conv_done <= 1'b0;
			conv_result <= '0;
		end
		else
		begin
			conv_done <= run_q && wait_q == 2'h2;
			if (conv_start)
			begin
				run_q <= 1'b1;
				wait_q <= 2'h0;
				chan_q <= conv_channel;
			end
			else if (run_q)
				wait_q <= wait_q + 2'h1;
			if (run_q && wait_q == 2'h2)
			begin
				run_q <= 1'b0;
				// Only channel 0 reports a compare hit
				conv_result <= {chan_q, 8'h00, chan_q, chan_q == 4'h0};
			end
			else
				conv_result <= ~conv_result;
		end
	end
endmodule : ats_partner
`default_nettype wire

// ### verification/ats_sequencer_bench.sv
// Scenario bench for the trigger sequencer
`timescale 1ns/1ps
`default_nettype none
module ats_sequencer_bench
	import ats_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	ats_cfg_type cfg = '{default: 1'b0, trig_source: 4'hf};
	ats_irq_cfg_type irq = '0;
	logic [15:0] dien = 16'h0000;
	logic [15:0] ace = 16'h0000;
	logic [15:0] pad = 16'h0000;
	logic sw_start = 1'b0;
	logic clr = 1'b0;
	logic cmp_wr = 1'b0;
	logic [11:0] cval = 12'h000;
	logic conv_done, conv_start, pwr, busy, ovr, sdone, cmpf, sirq, cirq;
	logic rvalid;
	logic [3:0] chan;
	logic [15:0] dport;
	ats_conv_type res;
	int mismatches = 0;
	int comparisons = 0;
	int starts = 0;
	int results = 0;
	int s0, r0;
	always #5 clk = ~clk;
	// Tally launches and stored results
	always @(posedge clk)
	begin
		starts <= starts + int'(conv_start);
		results <= results + int'(rvalid);
	end
	ats_sequencer i_ats_sequencer (.clk(clk), .rst(rst), .cfg(cfg),
		.irq_cfg(irq), .digital_input_enable(dien),
		.auto_compare_en(ace), .sw_start(sw_start), .overrun_clear(clr),
		.seq_done_clear(clr), .compare_clear(clr), .pad_in(pad),
		.conv_done(conv_done), .conv_result(res), .cmp_wr(cmp_wr),
		.cmp_wr_channel(4'h0), .cmp_wr_value(cval),
		.conv_start(conv_start), .conv_channel(chan),
		.analog_power_on(pwr), .busy(busy), .trig_overrun_flag(ovr),
		.seq_done_flag(sdone), .compare_flag(cmpf),
		.seq_complete_irq(sirq), .compare_irq(cirq),
		.digital_port_in(dport), .result_value(), .result_channel(),
		.result_valid(rvalid));
	ats_partner i_ats_partner (.clk(clk), .rst(rst),
		.conv_start(conv_start), .conv_channel(chan),
		.conv_done(conv_done), .conv_result(res));
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic pulse_start();
		@(posedge clk) sw_start <= 1'b1;
		@(posedge clk) sw_start <= 1'b0;
	endtask : pulse_start
	// Compare value for channel 0, one write strobe
	task automatic cmp_write(logic [11:0] v);
		@(posedge clk);
		cmp_wr <= 1'b1;
		cval <= v;
		@(posedge clk);
		cmp_wr <= 1'b0;
	endtask : cmp_write
	// Reference point for the launch and result tallies
	task automatic mark();
		s0 = starts;
		r0 = results;
	endtask : mark
	task automatic wait_idle();
		int n;
		n = 0;
		// Leaves room for the two-flop trigger delay before busy rises
		tick(6);
		while (busy !== 1'b0 && n < 400)
		begin
			tick(1);
			n++;
		end
		chk("idle", 1, n < 400);
		tick(2);
	endtask : wait_idle
	task automatic t_single();
		irq <= '{1'b1, 1'b1, 1'b0};
		ace <= 16'h0001;
		cmp_write(12'h000);
		wait_idle();
		mark();
		pulse_start();
		wait_idle();
		tick(20);
		chk("starts", 8, starts - s0);
		chk("seq irq", 1, sirq);
		chk("cmp flag", 1, cmpf);
		chk("cmp irq", 1, cirq);
		irq.global_irq_mask <= 1'b1;
		tick(3);
		chk("masked", 0, {sirq, cirq});
		@(posedge clk) clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
		tick(2);
		chk("cleared", 0, {sdone, cmpf});
	endtask : t_single
	task automatic t_results();
		cmp_write(12'h001);
		mark();
		pulse_start();
		wait_idle();
		chk("results", 7, results - r0);
		chk("cmp miss", 0, cmpf);
	endtask : t_results
	task automatic t_scan();
		cfg.scan_mode <= 1'b1;
		pad[15] <= 1'b1;
		mark();
		pulse_start();
		tick(200);
		chk("scan runs", 1, starts - s0 > 16);
		cfg.scan_mode <= 1'b0;
		pad[15] <= 1'b0;
		wait_idle();
	endtask : t_scan
	task automatic t_edge();
		cfg.trig_enable <= 1'b1;
		cfg.trig_polarity <= 1'b1;
		tick(5);
		mark();
		pulse_start();
		tick(20);
		chk("sw refused", 0, starts - s0);
		pad[15] <= 1'b1;
		tick(15);
		pad[15] <= 1'b0;
		tick(4);
		pad[15] <= 1'b1;
		tick(6);
		chk("overrun", 1, ovr);
		wait_idle();
		cfg.trig_polarity <= 1'b0;
		@(posedge clk) clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
		wait_idle();
		mark();
		pad[15] <= 1'b0;
		wait_idle();
		chk("fall seq", 8, starts - s0);
	endtask : t_edge
	task automatic t_level();
		mark();
		cfg.trig_level_select <= 1'b1;
		cfg.trig_polarity <= 1'b1;
		pad[15] <= 1'b1;
		tick(150);
		pad[15] <= 1'b0;
		tick(3);
		pad[15] <= 1'b1;
		tick(3);
		chk("no overrun", 0, ovr);
		chk("level runs", 1, starts - s0 > 8);
		pad[15] <= 1'b0;
		wait_idle();
		mark();
		tick(30);
		chk("level stop", 0, starts - s0);
		cfg <= '{default: 1'b0, trig_source: 4'hf};
	endtask : t_level
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	// Watchdog far beyond the expected run of about a thousand cycles
	initial
	begin
		#200us;
		mismatches++;
		close_out();
	end
	initial
	begin
		tick(16);
		rst <= 1'b0;
		tick(2);
		chk("reset", 0, {pwr, busy, ovr, sdone, cmpf, sirq, cirq});
		dien <= 16'h00ff;
		pad <= 16'h0f0f;
		tick(6);
		chk("pads", 16'h000f, dport);
		pad <= 16'h0000;
		t_single();
		t_results();
		t_scan();
		t_edge();
		t_level();
		close_out();
	end
endmodule : ats_sequencer_bench
`default_nettype wire
